// File: verilog/dpmc_top.sv
// Register front end and relock control for the processor and auxiliary PLLs.
// Assumes rst_b_i is the power-up reset, an Avalon-MM master on clk_i,
// and that hardware reset, runtime reset, sleep and interrupts are asynchronous levels.
//
// Notes on behaviour
// - Each PLL multiplies the oscillator by the 6-bit field in bits 5:0.
// - Processor multiplier defaults to 16, auxiliary multiplier to 0.
// - Processor register resets only at power-up, kept through sleep and resets.
// - Auxiliary register returns to default on hardware reset, runtime reset, sleep.
// - Auxiliary multiplier zero disables the auxiliary PLL and its clock.
// - Any processor register write halts the system for 20 us; code halts only when byte lane 0 is enabled.
// - No execution during halt; interrupts held and delivered afterwards.
// - Auxiliary write does not halt; auxiliary clocks unstable up to 20 us.
// - Processor register reads invalid after any reset or sleep until written.
`timescale 1ns/1ns
`default_nettype none
module dpmc_top #(
   parameter int unsigned RELOCK_CYCLES = dpmc_pkg::RELOCK_CYC,
   parameter int unsigned IRQ_W         = dpmc_pkg::IRQ_W
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   // Avalon-MM slave
   input  wire logic [dpmc_pkg::ADDR_W-1:0]  avs_address_i,
   input  wire logic                         avs_read_i,
   input  wire logic                         avs_write_i,
   input  wire logic [dpmc_pkg::DATA_W-1:0]  avs_writedata_i,
   input  wire logic [3:0]                   avs_byteenable_i,
   output logic      [dpmc_pkg::DATA_W-1:0]  avs_readdata_o,
   output logic                              avs_waitrequest_o,
   // System reset and power events
   input  wire logic                         hw_reset_i,
   input  wire logic                         runtime_reset_i,
   input  wire logic                         sleep_i,
   // Interrupts towards the processor
   input  wire logic [IRQ_W-1:0]             irq_i,
   output logic      [IRQ_W-1:0]             irq_o,
   // PLL control
   output logic      [dpmc_pkg::MULT_W-1:0]  cpu_mult_o,
   output logic      [dpmc_pkg::MULT_W-1:0]  aux_mult_o,
   output logic                              aux_pll_enable_o,
   output logic                              cpu_halt_o,
   output logic                              aux_settling_o
);
   localparam int unsigned EV_W = 3;

   // Synchronised events and interrupts
   logic [EV_W-1:0]  ev_sync;
   logic             hw_rst_s;
   logic             rt_rst_s;
   logic             sleep_s;
   logic             any_reset;
   logic [IRQ_W-1:0] irq_sync;

   // Bus handshake
   logic             wait_q;
   logic             req;
   logic             acc;
   logic             acc_wr;
   logic             hit_cpu;
   logic             hit_aux;
   logic             wr_cpu;
   logic             wr_aux;
   logic [31:0]      rdata_d;
   logic [31:0]      rdata_q;

   // Register state
   logic [5:0]       cpu_mult_q;
   logic [5:0]       aux_mult_q;
   logic             cpu_valid_q;
   logic             aux_valid_q;
   logic             aux_en_q;
   logic [IRQ_W-1:0] irq_pend_q;
   logic [IRQ_W-1:0] irq_q;
   logic             halt;
   logic             settle;

   dpmc_timer_if cpu_tmr ();
   dpmc_timer_if aux_tmr ();

   dpmc_sync #(
      .W       (EV_W)
   ) u_ev_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({sleep_i, runtime_reset_i, hw_reset_i}),
      .q_o     (ev_sync)
   );

   dpmc_sync #(
      .W       (IRQ_W)
   ) u_irq_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (irq_i),
      .q_o     (irq_sync)
   );

   assign hw_rst_s  = ev_sync[0];
   assign rt_rst_s  = ev_sync[1];
   assign sleep_s   = ev_sync[2];
   assign any_reset = hw_rst_s | rt_rst_s | sleep_s;

   dpmc_relock_timer #(
      .CYCLES  (RELOCK_CYCLES)
   ) u_cpu_relock (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .tmr     (cpu_tmr.tmr)
   );

   dpmc_relock_timer #(
      .CYCLES  (RELOCK_CYCLES)
   ) u_aux_relock (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .tmr     (aux_tmr.tmr)
   );

   assign halt   = cpu_tmr.busy;
   assign settle = aux_tmr.busy;

   // Access decode; the access completes on the edge where waitrequest is low
   assign req     = avs_read_i | avs_write_i;
   assign acc     = req & ~wait_q;
   assign acc_wr  = acc & avs_write_i;
   assign hit_cpu = (avs_address_i == dpmc_pkg::OFF_CPU_PLL);
   assign hit_aux = (avs_address_i == dpmc_pkg::OFF_AUX_PLL);
   // Only the low byte lane carries writable bits
   assign wr_cpu  = acc_wr & hit_cpu & avs_byteenable_i[0];
   assign wr_aux  = acc_wr & hit_aux & avs_byteenable_i[0];

   // Every processor register write enabling byte lane 0 restarts the halt
   assign cpu_tmr.start = wr_cpu;
   // Auxiliary write outside any reset or sleep opens a settle window, never a halt
   assign aux_tmr.start = wr_aux & ~any_reset;

   // Bus stalls while the processor is halted
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q & ~halt);
      end
   end

   // Read mux, captured one cycle ahead of the completing edge
   always_comb begin
      rdata_d = dpmc_pkg::UNMAPPED_DATA;
      unique case (avs_address_i)
         dpmc_pkg::OFF_CPU_PLL: begin
            // Invalid processor value reads as zero
            if (cpu_valid_q) begin
               rdata_d[dpmc_pkg::MULT_MSB:dpmc_pkg::MULT_LSB] = cpu_mult_q;
            end
         end
         dpmc_pkg::OFF_AUX_PLL: begin
            if (aux_valid_q) begin
               rdata_d[dpmc_pkg::MULT_MSB:dpmc_pkg::MULT_LSB] = aux_mult_q;
            end
         end
         dpmc_pkg::OFF_STATUS: begin
            rdata_d[dpmc_pkg::ST_CPU_VALID]  = cpu_valid_q;
            rdata_d[dpmc_pkg::ST_AUX_VALID]  = aux_valid_q;
            rdata_d[dpmc_pkg::ST_CPU_HALT]   = halt;
            rdata_d[dpmc_pkg::ST_AUX_SETTLE] = settle;
            rdata_d[dpmc_pkg::ST_AUX_ON]     = aux_en_q;
         end
         default: begin
            rdata_d = dpmc_pkg::UNMAPPED_DATA;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= dpmc_pkg::UNMAPPED_DATA;
      end else if (avs_read_i & wait_q & ~halt) begin
         rdata_q <= rdata_d;
      end
   end

   // Processor multiplier reset to 16 only by power-up reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cpu_mult_q <= dpmc_pkg::CPU_MULT_RST;
      end else if (wr_cpu) begin
         // Multiplier field only; reserved bits dropped
         cpu_mult_q <= avs_writedata_i[dpmc_pkg::MULT_MSB:dpmc_pkg::MULT_LSB];
      end
   end

   // Readback valid only after a write since the last reset or sleep
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cpu_valid_q <= 1'b0;
      end else if (any_reset) begin
         cpu_valid_q <= 1'b0;
      end else if (wr_cpu) begin
         cpu_valid_q <= 1'b1;
      end
   end

   // Auxiliary multiplier held at default during any reset or sleep
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aux_mult_q  <= dpmc_pkg::AUX_MULT_RST;
         aux_valid_q <= 1'b0;
      end else if (any_reset) begin
         aux_mult_q  <= dpmc_pkg::AUX_MULT_RST;
         aux_valid_q <= 1'b0;
      end else if (wr_aux) begin
         aux_mult_q  <= avs_writedata_i[dpmc_pkg::MULT_MSB:dpmc_pkg::MULT_LSB];
         aux_valid_q <= 1'b1;
      end
   end

   // Zero multiplier switches the auxiliary PLL off
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aux_en_q <= 1'b0;
      end else begin
         aux_en_q <= (aux_mult_q != dpmc_pkg::AUX_MULT_OFF);
      end
   end

   // Interrupts caught during the halt are held; release clears the hold even if one arrives then
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_pend_q <= '0;
      end else if (halt) begin
         irq_pend_q <= irq_pend_q | irq_sync;
      end else begin
         irq_pend_q <= '0;
      end
   end

   // Held interrupts delivered in the second cycle after the halt
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_q <= '0;
      end else if (halt) begin
         irq_q <= '0;
      end else begin
         irq_q <= irq_sync | irq_pend_q;
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign irq_o             = irq_q;
   assign cpu_mult_o        = cpu_mult_q;
   assign aux_mult_o        = aux_mult_q;
   assign aux_pll_enable_o  = aux_en_q;
   assign cpu_halt_o        = halt;
   assign aux_settling_o    = settle;
endmodule : dpmc_top
`default_nettype wire

// File: verilog/dpmc_pkg.sv
// Constants for the dual PLL multiplier control block.
// Assumes a 250 MHz register clock and byte addresses on the bus.
package dpmc_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned MULT_W        = 6;
   // Register byte offsets
   localparam logic [7:0]  OFF_CPU_PLL   = 8'h60;
   localparam logic [7:0]  OFF_AUX_PLL   = 8'h64;
   localparam logic [7:0]  OFF_STATUS    = 8'h68;
   // Field positions
   localparam int unsigned MULT_LSB      = 0;
   localparam int unsigned MULT_MSB      = 5;
   localparam int unsigned ST_CPU_VALID  = 0;
   localparam int unsigned ST_AUX_VALID  = 1;
   localparam int unsigned ST_CPU_HALT   = 2;
   localparam int unsigned ST_AUX_SETTLE = 3;
   localparam int unsigned ST_AUX_ON     = 4;
   // Reset values
   localparam logic [5:0]  CPU_MULT_RST  = 6'h10;
   localparam logic [5:0]  AUX_MULT_RST  = 6'h00;
   localparam logic [5:0]  AUX_MULT_OFF  = 6'h00;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned RELOCK_US     = 20;
   localparam int unsigned RELOCK_CYC    = (RELOCK_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned IRQ_W         = 8;
endpackage : dpmc_pkg

// File: verilog/dpmc_timer_if.sv
// Start/busy pair between the top and one relock timer.
// Assumes both ends share the top's clock.
`timescale 1ns/1ns
`default_nettype none
interface dpmc_timer_if;
   logic start;
   logic busy;
   modport ctl (output start, input busy);
   modport tmr (input start, output busy);
endinterface : dpmc_timer_if
`default_nettype wire

// File: verilog/dpmc_relock_timer.sv
// Down counter that stays busy for CYCLES clocks after each start.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dpmc_relock_timer #(
   parameter int unsigned CYCLES = dpmc_pkg::RELOCK_CYC
) (
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   dpmc_timer_if.tmr   tmr
);
   localparam int unsigned CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] count_q;
   logic             busy_q;

   // Restart wins over a running count
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_q <= '0;
         busy_q  <= 1'b0;
      end else if (tmr.start) begin
         count_q <= LOAD;
         busy_q  <= 1'b1;
      end else if (busy_q) begin
         if (count_q == '0) begin
            busy_q <= 1'b0;
         end else begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   assign tmr.busy = busy_q;
endmodule : dpmc_relock_timer
`default_nettype wire

// File: verilog/dpmc_sync.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes the bits need no mutual coherence.
`timescale 1ns/1ns
`default_nettype none
module dpmc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule : dpmc_sync
`default_nettype wire

// File: tb/dpmc_top_properties.sv
// Checker for the PLL multiplier block, bound to its top module.
// Assumes one clock domain and the async power-up reset.
`timescale 1ns/1ns
`default_nettype none
module dpmc_top_properties #(
   parameter int unsigned RELOCK_CYCLES = dpmc_pkg::RELOCK_CYC,
   parameter int unsigned IRQ_W         = dpmc_pkg::IRQ_W
) (
   input wire logic             clk_i,
   input wire logic             rst_b_i,
   input wire logic [7:0]       avs_address_i,
   input wire logic             avs_write_i,
   input wire logic [31:0]      avs_writedata_i,
   input wire logic [3:0]       avs_byteenable_i,
   input wire logic             avs_waitrequest_o,
   input wire logic             hw_reset_i,
   input wire logic             runtime_reset_i,
   input wire logic             sleep_i,
   input wire logic [IRQ_W-1:0] irq_o,
   input wire logic [5:0]       cpu_mult_o,
   input wire logic [5:0]       aux_mult_o,
   input wire logic             aux_pll_enable_o,
   input wire logic             cpu_halt_o,
   input wire logic             aux_settling_o
);
   wire logic  wr_ok  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   wire logic  cpu_wr = wr_ok && avs_address_i == dpmc_pkg::OFF_CPU_PLL;
   wire logic  aux_wr = wr_ok && avs_address_i == dpmc_pkg::OFF_AUX_PLL;
   logic [15:0] halt_n_q;
   // Halt length so far; a counter avoids a long repetition
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) halt_n_q <= 16'h0000;
      else halt_n_q <= cpu_halt_o ? halt_n_q + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_cpu_store;
      cpu_wr |=> {26'h0, cpu_mult_o} == ($past(avs_writedata_i) & 32'h0000_003f);
   endproperty
   a_cpu_store: assert property (p_cpu_store) else $error("cpu multiplier not stored");
   property p_cpu_keep;
      !$stable(cpu_mult_o) |-> $past(cpu_wr);
   endproperty
   a_cpu_keep: assert property (p_cpu_keep) else $error("cpu multiplier changed unasked");
   property p_aux_clear;
      (hw_reset_i || runtime_reset_i || sleep_i) [*4] |-> aux_mult_o == 6'h00;
   endproperty
   a_aux_clear: assert property (p_aux_clear) else $error("aux multiplier not cleared");
   property p_aux_en;
      $stable(aux_mult_o) |-> aux_pll_enable_o == (aux_mult_o != 6'h00);
   endproperty
   a_aux_en: assert property (p_aux_en) else $error("aux enable wrong");
   property p_halt_start;
      cpu_wr |=> cpu_halt_o;
   endproperty
   a_halt_start: assert property (p_halt_start) else $error("no halt after cpu write");
   property p_halt_len;
      $fell(cpu_halt_o) |-> halt_n_q == 16'(RELOCK_CYCLES);
   endproperty
   a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
   property p_irq_hold;
      cpu_halt_o && $past(cpu_halt_o) |-> irq_o == '0;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt during halt");
   property p_aux_settle;
      aux_wr |=> aux_settling_o && !cpu_halt_o;
   endproperty
   a_aux_settle: assert property (p_aux_settle) else $error("aux write halted");
endmodule : dpmc_top_properties
bind dpmc_top dpmc_top_properties #(.RELOCK_CYCLES(RELOCK_CYCLES), .IRQ_W(IRQ_W)) u_props (
   .clk_i, .rst_b_i, .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_waitrequest_o, .hw_reset_i, .runtime_reset_i, .sleep_i, .irq_o, .cpu_mult_o,
   .aux_mult_o, .aux_pll_enable_o, .cpu_halt_o, .aux_settling_o);
`default_nettype wire

// File: tb/tb_dpmc_top.sv
// Self-checking bench for the PLL multiplier block.
// Drives the Avalon-MM port and power events itself; no partner model.
`timescale 1ns/1ns
`default_nettype none
module tb_dpmc_top;
   localparam int unsigned RLK = 20;
   logic        clk_i = 1'b0;
   logic        rst_b_i;
   logic [7:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        hw_reset_i;
   logic        runtime_reset_i;
   logic        sleep_i;
   logic [7:0]  irq_i;
   logic [7:0]  irq_o;
   logic [5:0]  cpu_mult_o;
   logic [5:0]  aux_mult_o;
   logic        aux_pll_enable_o;
   logic        cpu_halt_o;
   logic        aux_settling_o;
   logic [31:0] rd;
   int          fails = 0;
   int          n_compared = 0;
   always #2 clk_i = ~clk_i;
   dpmc_top #(.RELOCK_CYCLES(RLK)) dut (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .hw_reset_i,
      .runtime_reset_i, .sleep_i, .irq_i, .irq_o, .cpu_mult_o, .aux_mult_o, .aux_pll_enable_o,
      .cpu_halt_o, .aux_settling_o);
   task automatic complete_run;
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Request stands until the rising edge that samples waitrequest low; data taken there
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i    <= a;
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      avs_write_i      <= wr;
      avs_read_i       <= !wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      // Idle waitrequest is high, so at least one wait state
      chk(32'(n >= 2), 32'h1);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask : bus
   task automatic t_por;
      @(negedge clk_i);
      chk({aux_pll_enable_o, cpu_mult_o, aux_mult_o}, {1'b0, 6'h10, 6'h00});
      bus(1'b0, dpmc_pkg::OFF_CPU_PLL, 32'h0, 4'hf);
      chk(rd, 32'h0);
   endtask : t_por
   task automatic t_cpu(input logic [31:0] v);
      int  n;
      time t0;
      n = 0;
      bus(1'b1, dpmc_pkg::OFF_CPU_PLL, v, 4'hf);
      t0 = $time;
      fork
         begin
            // One-cycle pulse inside the halt must still arrive afterwards
            irq_i <= 8'h01;
            @(posedge clk_i);
            irq_i <= 8'h00;
            while (cpu_halt_o === 1'b1 && n < 100) begin
               chk(irq_o, 32'h0);
               n++;
               @(posedge clk_i);
            end
            chk(n, RLK);
            @(posedge clk_i);
            chk(irq_o, 32'h1);
            @(posedge clk_i);
            chk(irq_o, 32'h0);
         end
         begin
            bus(1'b0, dpmc_pkg::OFF_CPU_PLL, 32'h0, 4'hf);
            chk(rd, v);
            chk(($time - t0) > RLK * 4, 32'h1);
         end
      join
      chk(cpu_mult_o, v);
      repeat (4) @(posedge clk_i);
   endtask : t_cpu
   task automatic t_aux(input logic [31:0] v);
      bus(1'b1, dpmc_pkg::OFF_AUX_PLL, v, 4'hf);
      @(negedge clk_i);
      chk({cpu_halt_o, aux_settling_o}, 32'h1);
      repeat (2) @(negedge clk_i);
      chk({aux_pll_enable_o, aux_mult_o}, {v != 32'h0, v[5:0]});
      bus(1'b0, dpmc_pkg::OFF_AUX_PLL, 32'h0, 4'hf);
      chk(rd, v);
      bus(1'b0, dpmc_pkg::OFF_STATUS, 32'h0, 4'hf);
      chk(rd, {27'h0, v != 32'h0, 4'hb});
   endtask : t_aux
   task automatic t_event(input int i);
      t_cpu(32'h1f);
      t_aux(32'h2e);
      @(posedge clk_i);
      {sleep_i, runtime_reset_i, hw_reset_i} <= 3'b001 << i;
      repeat (6) @(posedge clk_i);
      {sleep_i, runtime_reset_i, hw_reset_i} <= 3'b000;
      repeat (4) @(negedge clk_i);
      chk({cpu_mult_o, aux_mult_o}, {6'h1f, 6'h00});
      bus(1'b0, dpmc_pkg::OFF_CPU_PLL, 32'h0, 4'hf);
      chk(rd, 32'h0);
      bus(1'b0, dpmc_pkg::OFF_AUX_PLL, 32'h0, 4'hf);
      chk(rd, 32'h0);
   endtask : t_event
   task automatic t_refuse;
      bus(1'b1, 8'h70, 32'h0000_0015, 4'hf);
      bus(1'b0, 8'h70, 32'h0, 4'hf);
      chk(rd, 32'h0);
      bus(1'b1, dpmc_pkg::OFF_AUX_PLL, 32'h0000_0015, 4'he);
      @(negedge clk_i);
      chk(aux_mult_o, 32'h0);
   endtask : t_refuse
   initial begin
      rst_b_i = 1'b0;
      avs_address_i = 8'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      {sleep_i, runtime_reset_i, hw_reset_i} = 3'b000;
      irq_i = 8'h00;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_por();
      t_cpu(32'h2e);
      t_cpu(32'h2e);
      t_cpu(32'h10);
      t_aux(32'h08);
      t_aux(32'h2e);
      t_aux(32'h00);
      for (int i = 0; i < 3; i++) begin
         t_event(i);
      end
      t_refuse();
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_por();
      complete_run();
   end
   // Full run needs well under 20 us
   initial begin
      #100000;
      fails++;
      complete_run();
   end
endmodule : tb_dpmc_top
`default_nettype wire
